// ===== design/fsc_pkg.sv
// constants, register map and carrier types for the flash security and clock divider
// assumes a byte-wide flash array and a 16-bit cpu address space
package fsc_pkg;
  localparam logic [4:0] FSC_REG_DIV = 5'h00;
  localparam logic [4:0] FSC_REG_CFG = 5'h04;
  localparam logic [4:0] FSC_REG_OPT = 5'h08;
  localparam logic [4:0] FSC_REG_PROT = 5'h0C;
  localparam logic [4:0] FSC_REG_STAT = 5'h10;
  // ratio register fields
  localparam int FSC_DIV_SET_BIT = 7;
  localparam int FSC_DIV_PRE_BIT = 6;
  localparam logic [7:0] FSC_DIV_RST = 8'h00;
  // config and options fields
  localparam int FSC_CFG_KEY_WRITE_ACCESS_BIT = 5;
  localparam int FSC_OPT_BACKDOOR_UNLOCK_ENABLE_BIT = 7;
  localparam logic [1:0] FSC_SEC_UNSECURED = 2'h2;
  // status fields
  localparam int FSC_ST_SECURED_BIT = 2;
  localparam int FSC_ST_DBGEN_BIT = 3;
  localparam int FSC_ST_BKGD_BIT = 4;
  localparam int FSC_ST_ACCERR_BIT = 5;
  localparam int FSC_ST_SET_BIT = 6;
  localparam int FSC_ST_BUSY_BIT = 7;
  // timing and key entry
  localparam logic [2:0] FSC_PRESCALE_LAST = 3'h7;
  localparam int FSC_KEY_BYTES = 8;
  localparam logic [3:0] FSC_KEY_LAST = 4'h8;
  localparam int FSC_TIMING_MIN_KHZ = 150;
  localparam int FSC_TIMING_MAX_KHZ = 200;

  typedef struct packed {
    logic valid;
    logic write;
    logic debug;
    logic secureSrc;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fsc_memreq_s;

  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } fsc_avreq_s;
endpackage : fsc_pkg

// ===== design/fsc_flash_security.sv
// flash security gate, backdoor key unlock and write-once flash clock divider
// assumes an avalon-mm master on clk_sys and a command engine that requests timed ops
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
module fsc_flash_security #(
  parameter logic [15:0] FLASH_BASE = 16'h1860,
  parameter logic [15:0] RAM_BASE = 16'h0070,
  parameter logic [15:0] RAM_LAST = 16'h086F,
  parameter logic [15:0] KEY_BASE = 16'hFFB0,
  parameter int OP_CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire fsc_pkg::fsc_avreq_s avReq,
  output logic avWaitrequest,
  output logic [31:0] avReaddata,
  input wire logic [7:0] nonvolatileOptionsByte,
  input wire logic [7:0] nonvolatileProtectByte,
  input wire logic [63:0] backdoorCompareBytes,
  input wire logic backgroundModePin,
  input wire logic dbgProtWrite,
  input wire logic [7:0] dbgProtData,
  input wire logic blankCheckPass,
  input wire fsc_pkg::fsc_memreq_s memReq,
  input wire logic [7:0] memRdata,
  output fsc_pkg::fsc_memreq_s memFwd,
  output logic [7:0] cpuRdata,
  input wire logic opStart,
  input wire logic [OP_CNT_W-1:0] opPulses,
  output logic opBusy,
  output logic opDone,
  output logic flashTimingTick,
  output logic progEraseEnable,
  output logic debugModuleEnable,
  output logic activeBackgroundMode,
  output logic [7:0] blockProtect
);
  import fsc_pkg::*;

  typedef struct packed {
    logic [7:0] ratio;
    logic [7:0] opts;
    logic [7:0] prot;
    logic keyAccess;
    logic [3:0] keyIdx;
    logic keyOk;
    logic accErr;
    logic pinS1;
    logic pinS2;
    logic rstDone;
    logic bkgdMode;
    logic [2:0] pre;
    logic [5:0] divCnt;
    logic tick;
    logic busy;
    logic done;
    logic [OP_CNT_W-1:0] opCnt;
    logic ack;
    logic [31:0] rdata;
    fsc_memreq_s fwd;
    logic rdAllow;
    logic [7:0] cpuRd;
  } fsc_state_s;

  fsc_state_s st;
  fsc_state_s next_st;

  logic secured;
  logic busWr;
  logic busRd;
  logic keyHit;
  logic blocked;
  logic preEn;

  function automatic logic inFlash(input logic [15:0] a);
    inFlash = (a >= FLASH_BASE);
  endfunction : inFlash

  function automatic logic inSecureMem(input logic [15:0] a);
    inSecureMem = inFlash(a) || (a >= RAM_BASE && a <= RAM_LAST);
  endfunction : inSecureMem

  function automatic logic inKeyRange(input logic [15:0] a);
    inKeyRange = (a >= KEY_BASE) && (a - KEY_BASE < 16'(FSC_KEY_BYTES));
  endfunction : inKeyRange

  assign secured = (st.opts[1:0] != FSC_SEC_UNSECURED);
  // writes land at the second edge, reads at the first, so readdata is already held in a flop
  assign avWaitrequest = (avReq.read || avReq.write) && !st.ack;
  assign busWr = avReq.write && st.ack && avReq.byteenable[0];
  assign busRd = avReq.read && !st.ack;
  assign keyHit = memReq.valid && memReq.write && st.keyAccess && inKeyRange(memReq.addr);
  assign blocked = secured && inSecureMem(memReq.addr) && (memReq.debug || !memReq.secureSrc);
  assign preEn = st.ratio[FSC_DIV_PRE_BIT] ? (st.pre == FSC_PRESCALE_LAST) : 1'b1;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    next_st.done = 1'b0;
    next_st.pinS1 = backgroundModePin;
    next_st.pinS2 = st.pinS1;
    next_st.ack = (avReq.read || avReq.write) && !st.ack;

    // flash timing clock: bus or bus/8, then divide by field plus one
    next_st.pre = st.pre + 3'h1;
    if (st.ratio[FSC_DIV_SET_BIT] && preEn) begin
      if (st.divCnt == st.ratio[5:0]) begin
        next_st.divCnt = 6'h00;
        next_st.tick = 1'b1;
      end else begin
        next_st.divCnt = st.divCnt + 6'h01;
      end
    end

    // timed ops count whole ticks; a start before the ratio is set is ignored
    if (opStart && !st.busy && st.ratio[FSC_DIV_SET_BIT] && opPulses != '0) begin
      next_st.busy = 1'b1;
      next_st.opCnt = opPulses;
    end else if (st.busy && st.tick) begin
      next_st.opCnt = st.opCnt - 1'b1;
      if (st.opCnt == OP_CNT_W'(1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end

    // memory path gate, one cycle of latency on both directions
    next_st.fwd = memReq;
    next_st.fwd.valid = memReq.valid && !blocked && !keyHit;
    next_st.rdAllow = !blocked;
    next_st.cpuRd = st.rdAllow ? memRdata : 8'h00;

    // key comparison writes from secure code only
    if (keyHit && memReq.secureSrc && !memReq.debug && st.keyIdx != FSC_KEY_LAST) begin
      if (memReq.addr[2:0] != st.keyIdx[2:0] ||
          memReq.wdata != backdoorCompareBytes[8*(7-st.keyIdx[2:0]) +: 8]) begin
        next_st.keyOk = 1'b0;
      end
      next_st.keyIdx = st.keyIdx + 4'h1;
    end

    // a flash write before the ratio is set is a protocol violation
    if (memReq.valid && memReq.write && !keyHit && !blocked && inFlash(memReq.addr) &&
        !st.ratio[FSC_DIV_SET_BIT]) begin
      next_st.accErr = 1'b1;
    end

    if (dbgProtWrite) begin
      next_st.prot = dbgProtData;
    end

    // blank check pass forces the code open until reset
    if (blankCheckPass) begin
      next_st.opts[1:0] = FSC_SEC_UNSECURED;
    end

    if (busRd) begin
      next_st.rdata = 32'h0000_0000;
      if (avReq.address == FSC_REG_DIV) begin
        next_st.rdata[7:0] = st.ratio;
      end else if (avReq.address == FSC_REG_CFG) begin
        next_st.rdata[FSC_CFG_KEY_WRITE_ACCESS_BIT] = st.keyAccess;
      end else if (avReq.address == FSC_REG_OPT) begin
        next_st.rdata[7:0] = st.opts;
      end else if (avReq.address == FSC_REG_PROT) begin
        next_st.rdata[7:0] = st.prot;
      end else if (avReq.address == FSC_REG_STAT) begin
        next_st.rdata[1:0] = st.opts[1:0];
        next_st.rdata[FSC_ST_SECURED_BIT] = secured;
        next_st.rdata[FSC_ST_DBGEN_BIT] = !secured;
        next_st.rdata[FSC_ST_BKGD_BIT] = st.bkgdMode;
        next_st.rdata[FSC_ST_ACCERR_BIT] = st.accErr;
        next_st.rdata[FSC_ST_SET_BIT] = st.ratio[FSC_DIV_SET_BIT];
        next_st.rdata[FSC_ST_BUSY_BIT] = st.busy;
      end
    end

    if (busWr) begin
      if (avReq.address == FSC_REG_DIV) begin
        // only the first write lands; later ones are dropped silently
        if (!st.ratio[FSC_DIV_SET_BIT]) begin
          next_st.ratio = {1'b1, avReq.writedata[6:0]};
        end
      end else if (avReq.address == FSC_REG_CFG) begin
        if (avReq.writedata[FSC_CFG_KEY_WRITE_ACCESS_BIT] && !st.keyAccess) begin
          next_st.keyIdx = 4'h0;
          next_st.keyOk = 1'b1;
        end
        if (!avReq.writedata[FSC_CFG_KEY_WRITE_ACCESS_BIT] && st.keyAccess) begin
          // mismatch or short entry keeps the code as it was
          if (st.opts[FSC_OPT_BACKDOOR_UNLOCK_ENABLE_BIT] && st.keyOk && st.keyIdx == FSC_KEY_LAST) begin
            next_st.opts[1:0] = FSC_SEC_UNSECURED;
          end
        end
        next_st.keyAccess = avReq.writedata[FSC_CFG_KEY_WRITE_ACCESS_BIT];
      end else if (avReq.address == FSC_REG_STAT) begin
        // set wins: an error in this cycle survives the clear
        if (avReq.writedata[FSC_ST_ACCERR_BIT] && !next_st.accErr) begin
          next_st.accErr = 1'b0;
        end else if (avReq.writedata[FSC_ST_ACCERR_BIT] && st.accErr && next_st.accErr) begin
          next_st.accErr = memReq.valid && memReq.write && !keyHit && !blocked &&
                           inFlash(memReq.addr) && !st.ratio[FSC_DIV_SET_BIT];
        end
      end
    end

    // first cycle after release samples the background pin
    if (!st.rstDone) begin
      next_st.rstDone = 1'b1;
      next_st.bkgdMode = !st.pinS2;
    end

    if (srst) begin
      next_st = '0;
      next_st.pinS1 = backgroundModePin;
      next_st.pinS2 = st.pinS1;
      next_st.ratio = FSC_DIV_RST;
      next_st.opts = nonvolatileOptionsByte;
      next_st.prot = nonvolatileProtectByte;
      next_st.keyOk = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  assign avReaddata = st.rdata;
  assign memFwd = st.fwd;
  assign cpuRdata = st.cpuRd;
  assign opBusy = st.busy;
  assign opDone = st.done;
  assign flashTimingTick = st.tick;
  assign progEraseEnable = st.ratio[FSC_DIV_SET_BIT];
  assign debugModuleEnable = st.rstDone && !secured;
  assign activeBackgroundMode = st.bkgdMode;
  assign blockProtect = st.prot;
endmodule : fsc_flash_security

// ===== bench/fsc_mem_model.sv
// cpu-side memory that answers reads the security gate forwards
// assumes memRdata is wanted in the same cycle as memFwd
module fsc_mem_model
  import fsc_pkg::*;
(
  input wire logic clk_sys,
  input wire fsc_pkg::fsc_memreq_s memFwd,
  output logic [7:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] idle = 8'h00;
  // an idle bus toggles so a stale value never matches
  always @(posedge clk_sys) idle <= ~idle;
  assign memRdata = (memFwd.valid && !memFwd.write) ? memFwd.addr[7:0] ^ 8'h5A : idle;
endmodule : fsc_mem_model

// ===== bench/fsc_flash_security_sva.sv
// port checks for the flash security gate, divider and timed ops
// assumes a single clock domain; bound to every fsc_flash_security
module fsc_flash_security_sva
  import fsc_pkg::*;
#(
  parameter logic [15:0] FLASH_BASE = 16'h1860
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire fsc_pkg::fsc_memreq_s memReq,
  input wire fsc_pkg::fsc_memreq_s memFwd,
  input wire logic [7:0] cpuRdata,
  input wire logic opStart,
  input wire logic opBusy,
  input wire logic opDone,
  input wire logic flashTimingTick,
  input wire logic progEraseEnable,
  input wire logic debugModuleEnable,
  input wire logic activeBackgroundMode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // debug enable is not valid in the first cycle after reset
  sequence s_dbgFlash;
    !$past(srst) && memReq.valid && memReq.debug && !debugModuleEnable && memReq.addr >= FLASH_BASE;
  endsequence
  sequence s_secRead;
    memReq.valid && !memReq.write && !memReq.debug && memReq.secureSrc;
  endsequence
  a_drop_debug: assert property (s_dbgFlash |=> !memFwd.valid)
    else $error("debug access forwarded while secured");
  a_read_zero: assert property (s_dbgFlash ##0 !memReq.write |-> ##2 cpuRdata == 8'h00)
    else $error("blocked read returned data");
  a_fwd_secure: assert property (s_secRead |=> memFwd.valid && memFwd.addr == $past(memReq.addr))
    else $error("secure read not forwarded");
  a_op_gate: assert property (opStart && !progEraseEnable |=> !opBusy)
    else $error("op started before ratio set");
  a_tick_gate: assert property (!progEraseEnable |-> !flashTimingTick)
    else $error("timing tick before ratio set");
  a_flag_keep: assert property (progEraseEnable |=> progEraseEnable)
    else $error("ratio set flag dropped");
  a_done_once: assert property (opDone |-> $past(opBusy) ##1 !opDone)
    else $error("done not a single pulse after busy");
  a_bkgd_fixed: assert property (!$past(srst) && !$past(srst, 2) |-> $stable(activeBackgroundMode))
    else $error("background mode changed outside reset");
endmodule : fsc_flash_security_sva

bind fsc_flash_security fsc_flash_security_sva #(.FLASH_BASE(FLASH_BASE)) u_sva (.clk_sys, .srst,
  .memReq, .memFwd, .cpuRdata, .opStart, .opBusy, .opDone, .flashTimingTick, .progEraseEnable,
  .debugModuleEnable, .activeBackgroundMode);

// ===== bench/fsc_flash_security_tb_top.sv
// bench for the flash security gate: bus, gate, divider, key and blank check
// assumes fsc_mem_model on the far side and the bound checker
module fsc_flash_security_tb_top;
  import fsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] FB = 16'h1860;
  localparam logic [63:0] KEY = 64'h0123456789ABCDEF;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  fsc_avreq_s av = '0;
  fsc_memreq_s mrq = '0;
  fsc_memreq_s fwd;
  logic wt, busy, done, tick, pee, dme, fv, abm, os = 1'b0, bcp = 1'b0, dpw = 1'b0;
  logic bgp = 1'b1;
  logic [31:0] rd, q;
  logic [7:0] mr, cr, bp, got, nvo = 8'h83;
  int fail_count = 0, n_compared = 0, cyc = 0, n;
  fsc_flash_security uut (.clk_sys, .srst, .avReq(av), .avWaitrequest(wt), .avReaddata(rd),
    .nonvolatileOptionsByte(nvo), .nonvolatileProtectByte(8'hFF), .backdoorCompareBytes(KEY),
    .backgroundModePin(bgp), .dbgProtWrite(dpw), .dbgProtData(8'hDE), .blankCheckPass(bcp),
    .memReq(mrq), .memRdata(mr), .memFwd(fwd), .cpuRdata(cr), .opStart(os),
    .opPulses(16'h0002), .opBusy(busy), .opDone(done), .flashTimingTick(tick),
    .progEraseEnable(pee), .debugModuleEnable(dme), .activeBackgroundMode(abm), .blockProtect(bp));
  fsc_mem_model far (.clk_sys, .memFwd(fwd), .memRdata(mr));
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic avx(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    av <= '{address: a, read: !w, write: w, writedata: {24'h0, d}, byteenable: 4'hF};
    // settled waitrequest is seen mid-cycle; the access completes at the next rising edge
    @(negedge clk_sys);
    while (wt !== 1'b0) @(negedge clk_sys);
    @(posedge clk_sys);
    q = rd;
    av.read <= 1'b0;
    av.write <= 1'b0;
  endtask : avx
  task automatic mop(input logic w, d, s, input logic [15:0] a, input logic [7:0] wd);
    @(posedge clk_sys);
    mrq <= '{valid: 1'b1, write: w, debug: d, secureSrc: s, addr: a, wdata: wd};
    @(posedge clk_sys);
    mrq.valid <= 1'b0;
    @(negedge clk_sys);
    fv = fwd.valid;
    @(negedge clk_sys);
    got = cr;
  endtask : mop
  task automatic keyIn(input logic bad, input logic [1:0] e);
    avx(1'b1, FSC_REG_CFG, 8'h20);
    // one byte per request, spaced, in ascending order
    for (int i = 0; i < FSC_KEY_BYTES; i++) begin
      mop(1'b1, 1'b0, 1'b1, 16'hFFB0 + 16'(i), KEY[63-8*i -: 8] ^ {7'h0, bad && i == 5});
      chk("key fwd", fv, 1'b0);
    end
    avx(1'b1, FSC_REG_CFG, 8'h00);
    avx(1'b0, FSC_REG_STAT, 8'h00);
    chk("code", q[1:0], e);
  endtask : keyIn
  task automatic tGate;
    avx(1'b0, FSC_REG_OPT, 8'h00);
    chk("opt", q, 32'h83);
    chk("dbg en", dme, 1'b0);
    chk("prot", bp, 8'hFF);
    mop(1'b0, 1'b1, 1'b0, FB, 8'h00);
    chk("dbg rd", got, 8'h00);
    mop(1'b1, 1'b1, 1'b0, FB, 8'h33);
    chk("dbg wr", fv, 1'b0);
    mop(1'b0, 1'b0, 1'b1, FB, 8'h00);
    chk("sec rd", got, FB[7:0] ^ 8'h5A);
    mop(1'b1, 1'b0, 1'b1, FB, 8'h11);
    avx(1'b0, FSC_REG_STAT, 8'h00);
    chk("acc err", q[FSC_ST_ACCERR_BIT], 1'b1);
    avx(1'b1, FSC_REG_STAT, 8'h20);
    avx(1'b0, FSC_REG_STAT, 8'h00);
    chk("acc clr", q[FSC_ST_ACCERR_BIT], 1'b0);
    chk("bkgd off", abm, 1'b0);
    $display("gate test done");
  endtask : tGate
  task automatic tRatio;
    avx(1'b0, FSC_REG_DIV, 8'h00);
    chk("div rst", q, 32'h0);
    @(posedge clk_sys);
    os <= 1'b1;
    @(posedge clk_sys);
    os <= 1'b0;
    @(negedge clk_sys);
    chk("op off", busy, 1'b0);
    // 100 MHz / (8 * 64) lands inside the timing clock window
    avx(1'b1, FSC_REG_DIV, 8'h7F);
    avx(1'b1, FSC_REG_DIV, 8'h01);
    avx(1'b0, FSC_REG_DIV, 8'h00);
    chk("div", q, 32'hFF);
    chk("pe en", pee, 1'b1);
    while (tick !== 1'b1) @(negedge clk_sys);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (tick !== 1'b1);
    chk("period", n, 512);
    @(posedge clk_sys);
    os <= 1'b1;
    @(posedge clk_sys);
    os <= 1'b0;
    n = 0;
    @(negedge clk_sys);
    chk("busy", busy, 1'b1);
    while (done !== 1'b1) begin
      @(negedge clk_sys);
      n += tick;
    end
    chk("op ticks", n, 2);
    $display("ratio test done");
  endtask : tRatio
  task automatic tKey;
    keyIn(1'b1, 2'h3);
    keyIn(1'b0, FSC_SEC_UNSECURED);
    mop(1'b0, 1'b1, 1'b0, FB, 8'h00);
    chk("dbg rd", got, FB[7:0] ^ 8'h5A);
    chk("dbg en on", dme, 1'b1);
    $display("key test done");
  endtask : tKey
  task automatic tBlank;
    @(posedge clk_sys);
    srst <= 1'b1;
    nvo <= 8'h03;
    bgp <= 1'b0;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    bgp <= 1'b1;
    keyIn(1'b0, 2'h3);
    chk("bkgd on", abm, 1'b1);
    @(posedge clk_sys);
    bcp <= 1'b1;
    dpw <= 1'b1;
    @(posedge clk_sys);
    bcp <= 1'b0;
    dpw <= 1'b0;
    avx(1'b1, FSC_REG_PROT, 8'h00);
    chk("prot", bp, 8'hDE);
    avx(1'b0, FSC_REG_STAT, 8'h00);
    chk("blank", q[1:0], FSC_SEC_UNSECURED);
    $display("blank test done");
  endtask : tBlank
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    tGate();
    tRatio();
    tKey();
    tBlank();
    summarize();
  end
endmodule : fsc_flash_security_tb_top
